// file: hdl/gbpe_regs.svh
// gbpe_regs.svh: constants of the gpio blink/pwm expander port logic
// assumes: included by its bare name from the package and the top module
`ifndef GBPE_REGS_SVH
`define GBPE_REGS_SVH

// port counts
`define GBPE_NUM_IO        16
`define GBPE_NUM_OUT       17
`define GBPE_LO_W          8

// reset values
`define GBPE_DIR_RST       16'hffff
`define GBPE_REF_RST       16'h0000

// pwm timing
`define GBPE_OSC_FREQ_KHZ  32
`define GBPE_CLK_FREQ_KHZ  10000
`define GBPE_PWM_LAST      8'hef

`endif

// file: hdl/gbpe_pkg.sv
// gbpe_pkg.sv: types of the gpio blink/pwm expander port logic
// assumes: gbpe_regs.svh is on the include path
`include "gbpe_regs.svh"

package gbpe_pkg;

  typedef logic [`GBPE_NUM_OUT-1:0][3:0] gbpe_lvl_arr_t;

  // pwm configuration, supplied by the serial register file
  typedef struct packed {
    logic [`GBPE_NUM_OUT-1:0] out_en;
    logic                     global_en;
    logic [7:0]               global_lvl;
    logic [3:0]               master;
    gbpe_lvl_arr_t            indiv;
  } gbpe_pwm_cfg_t;

  // static and blink output levels, bit 16 is the shared pin
  typedef struct packed {
    logic [`GBPE_NUM_OUT-1:0] phase0;
    logic [`GBPE_NUM_OUT-1:0] phase1;
    logic                     blink_en;
    logic                     blink_flip;
  } gbpe_out_cfg_t;

endpackage

// file: hdl/gbpe_top.sv
// gbpe_top.sv: port logic of a 16-port open-drain expander with blink and pwm
// assumes: config comes from serial register logic on clk_sys; pins and the
// pwm oscillator are asynchronous and are synchronised here
// open-drain pins: an enable high pulls the pin low, data levels stay low
`timescale 1ns/1ps
`include "gbpe_regs.svh"

// How it works
// R1 - after reset all sixteen ports are inputs
// R2 - input levels always show real pin levels
// R3 - reading a half captures its reference snapshot
// R4 - inputs are compared against their captured reference
// R5 - any difference pulls shared pin low (irq)
// R6 - irq clears on return or on read
// R7 - shared pin: irq or seventeenth blinkable output
// R8 - blink off: phase zero levels drive outputs
// R9 - blink on: flip flag selects phase set
// R10 - pwm timing from the sampled oscillator clock
// R11 - pwm per output, others static glitch-free
// R12 - pwm fully off: static outputs, oscillator stopped
// R13 - master level sets window up to 225 of 240 counts
// R14 - per-output level scales within master window
// R15 - optional global level, 240 steps for all
// R16 - idle serial and no pwm means standby
// R17 - counter wraps each period, low below threshold
// R18 - phase switch happens on one edge for all
module gbpe_top
  import gbpe_pkg::*;
(
  input  wire logic                     clk_sys,
  input  wire logic                     sys_rst,
  input  wire logic [`GBPE_NUM_IO-1:0]  port_pin_i,
  output logic      [`GBPE_NUM_IO-1:0]  port_pin_o,
  output logic      [`GBPE_NUM_IO-1:0]  port_pin_oe,
  output logic                          irq_or_extra_output_pin_o,
  output logic                          irq_or_extra_output_pin_oe,
  input  wire logic                     pwm_osc_clk,
  input  wire logic [`GBPE_NUM_IO-1:0]  port_is_input,
  input  wire logic                     irq_pin_is_output,
  input  wire gbpe_out_cfg_t            out_cfg,
  input  wire gbpe_pwm_cfg_t            pwm_cfg,
  input  wire logic                     in_read_lo,
  input  wire logic                     in_read_hi,
  input  wire logic                     serial_busy,
  output logic      [`GBPE_NUM_IO-1:0]  in_level,
  output logic      [`GBPE_NUM_IO-1:0]  in_ref,
  output logic                          irq_pending,
  output logic                          osc_enable,
  output logic                          standby
);

  // pin synchroniser
  logic [`GBPE_NUM_IO-1:0]  pin_s1_ff;
  logic [`GBPE_NUM_IO-1:0]  pin_s2_ff;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pin_s1_ff <= '0;
      pin_s2_ff <= '0;
    end else begin
      pin_s1_ff <= port_pin_i;
      pin_s2_ff <= pin_s1_ff;
    end
  end

  // oscillator synchroniser and edge history
  logic                     osc_s1_ff;
  logic                     osc_s2_ff;
  logic                     osc_s3_ff;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      osc_s1_ff <= 1'b0;
      osc_s2_ff <= 1'b0;
      osc_s3_ff <= 1'b0;
    end else begin
      osc_s1_ff <= pwm_osc_clk;
      osc_s2_ff <= osc_s1_ff;
      osc_s3_ff <= osc_s2_ff;
    end
  end

  // port direction register
  logic [`GBPE_NUM_IO-1:0]  dir_in_ff;
  logic [`GBPE_NUM_IO-1:0]  nxt_dir_in;

  always_comb begin
    nxt_dir_in = port_is_input;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      dir_in_ff <= `GBPE_DIR_RST; // R1
    end else begin
      dir_in_ff <= nxt_dir_in;
    end
  end

  // input snapshot and transition detection
  logic [`GBPE_NUM_IO-1:0]  ref_ff;
  logic [`GBPE_NUM_IO-1:0]  nxt_ref;
  logic                     irq_ff;
  logic                     nxt_irq;
  logic [`GBPE_NUM_IO-1:0]  diff;

  always_comb begin
    nxt_ref    = ref_ff;
    if (in_read_lo) begin
      nxt_ref[`GBPE_LO_W-1:0] = pin_s2_ff[`GBPE_LO_W-1:0]; // R3
    end
    if (in_read_hi) begin
      nxt_ref[`GBPE_NUM_IO-1:`GBPE_LO_W] = pin_s2_ff[`GBPE_NUM_IO-1:`GBPE_LO_W]; // R3
    end
    diff    = (pin_s2_ff ^ nxt_ref) & dir_in_ff; // R4
    nxt_irq = |diff; // R5 R6
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ref_ff    <= `GBPE_REF_RST;
      irq_ff    <= 1'b0;
    end else begin
      ref_ff    <= nxt_ref;
      irq_ff    <= nxt_irq;
    end
  end

  // oscillator run request
  logic        osc_en_ff;
  logic        nxt_osc_en;

  always_comb begin
    nxt_osc_en = |pwm_cfg.out_en; // R12
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      osc_en_ff <= 1'b0;
    end else begin
      osc_en_ff <= nxt_osc_en;
    end
  end

  // pwm period counter on oscillator edges
  logic [7:0]  cnt_ff;
  logic [7:0]  nxt_cnt;
  logic        osc_rise;

  always_comb begin
    osc_rise   = osc_s2_ff & ~osc_s3_ff; // R10
    nxt_cnt    = cnt_ff;
    if (!osc_en_ff) begin
      nxt_cnt = 8'h00; // R12
    end else if (osc_rise) begin
      if (cnt_ff == `GBPE_PWM_LAST) begin
        nxt_cnt = 8'h00; // R17
      end else begin
        nxt_cnt = cnt_ff + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cnt_ff    <= 8'h00;
    end else begin
      cnt_ff    <= nxt_cnt;
    end
  end

  // per-output pwm threshold, widened before the product so it is not cut to 4 bits
  logic [`GBPE_NUM_OUT-1:0][7:0]  thr_ff;
  logic [`GBPE_NUM_OUT-1:0][7:0]  nxt_thr;

  genvar gi;
  generate
    for (gi = 0; gi < `GBPE_NUM_OUT; gi = gi + 1) begin : g_thr
      always_comb begin
        if (pwm_cfg.global_en) begin
          nxt_thr[gi] = pwm_cfg.global_lvl; // R15
        end else begin
          nxt_thr[gi] = 8'(pwm_cfg.master) * 8'(pwm_cfg.indiv[gi]); // R13 R14
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      thr_ff <= '0;
    end else begin
      thr_ff <= nxt_thr;
    end
  end

  // compare each output against the shared period count
  logic [`GBPE_NUM_OUT-1:0]  pwm_on;

  always_comb begin
    for (int i = 0; i < `GBPE_NUM_OUT; i++) begin
      pwm_on[i] = osc_en_ff & (cnt_ff < thr_ff[i]); // R17
    end
  end

  // blink phase select, one register so all bits switch on one edge
  logic                     phase_sel_ff;
  logic                     nxt_phase_sel;

  always_comb begin
    nxt_phase_sel = out_cfg.blink_en & out_cfg.blink_flip; // R9
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      phase_sel_ff <= 1'b0;
    end else begin
      phase_sel_ff <= nxt_phase_sel;
    end
  end

  // port pull-down enables
  logic [`GBPE_NUM_IO-1:0]  oe_ff;
  logic [`GBPE_NUM_IO-1:0]  nxt_oe;
  logic [`GBPE_NUM_OUT-1:0] lvl;
  logic [`GBPE_NUM_OUT-1:0] drive_low;

  always_comb begin
    if (phase_sel_ff) begin
      lvl = out_cfg.phase1; // R18
    end else begin
      lvl = out_cfg.phase0; // R8
    end
    drive_low = ~lvl & (~pwm_cfg.out_en | pwm_on); // R11
    nxt_oe    = drive_low[`GBPE_NUM_IO-1:0] & ~dir_in_ff; // R1
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      oe_ff <= '0;
    end else begin
      oe_ff <= nxt_oe;
    end
  end

  // shared pin: interrupt or seventeenth output
  logic                     irq_oe_ff;
  logic                     nxt_irq_oe;

  always_comb begin
    if (irq_pin_is_output) begin
      nxt_irq_oe = drive_low[`GBPE_NUM_IO]; // R7
    end else begin
      nxt_irq_oe = nxt_irq; // R5
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      irq_oe_ff <= 1'b0;
    end else begin
      irq_oe_ff <= nxt_irq_oe;
    end
  end

  // automatic standby
  logic                     standby_ff;
  logic                     nxt_standby;

  always_comb begin
    nxt_standby = ~serial_busy & ~nxt_osc_en; // R16
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      standby_ff <= 1'b0;
    end else begin
      standby_ff <= nxt_standby;
    end
  end

  // open-drain data levels: always low, the enables decide
  logic [`GBPE_NUM_IO-1:0]  pin_o_ff;
  logic [`GBPE_NUM_IO-1:0]  nxt_pin_o;
  logic                     irq_o_ff;
  logic                     nxt_irq_o;

  always_comb begin
    nxt_pin_o = '0;
    nxt_irq_o = 1'b0;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pin_o_ff <= '0;
      irq_o_ff <= 1'b0;
    end else begin
      pin_o_ff <= nxt_pin_o;
      irq_o_ff <= nxt_irq_o;
    end
  end

  // outputs
  assign port_pin_o                 = pin_o_ff;
  assign irq_or_extra_output_pin_o  = irq_o_ff;
  assign port_pin_oe                = oe_ff;
  assign irq_or_extra_output_pin_oe = irq_oe_ff;
  assign in_level                   = pin_s2_ff; // R2
  assign in_ref                     = ref_ff;
  assign irq_pending                = irq_ff;
  assign osc_enable                 = osc_en_ff;
  assign standby                    = standby_ff;

endmodule

// file: test/gbpe_top_assertions.sv
// checker: port-level properties of the expander port logic
// assumes: bound to gbpe_top, single clk_sys domain
`timescale 1ns/1ps
module gbpe_top_assertions
  import gbpe_pkg::*;
(
  input wire logic          clk_sys,
  input wire logic          sys_rst,
  input wire logic [15:0]   port_pin_oe,
  input wire logic          irq_or_extra_output_pin_oe,
  input wire logic [15:0]   port_is_input,
  input wire logic          irq_pin_is_output,
  input wire gbpe_out_cfg_t out_cfg,
  input wire gbpe_pwm_cfg_t pwm_cfg,
  input wire logic          in_read_lo,
  input wire logic          serial_busy,
  input wire logic [15:0]   in_level,
  input wire logic [15:0]   in_ref,
  input wire logic          irq_pending,
  input wire logic          osc_enable,
  input wire logic          standby
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence s_static(sel);
    (pwm_cfg.out_en == '0 && out_cfg.blink_en == sel && $stable(out_cfg)
     && $stable(port_is_input))[*3];
  endsequence
  a_reset_all_in: assert property (disable iff (1'b0) $fell(sys_rst) |->
    port_pin_oe == '0 && in_ref == '0 && !irq_pending) else $error("reset state wrong");
  a_read_snap_lo: assert property (in_read_lo |=>
    in_ref[7:0] == $past(in_level[7:0])) else $error("snapshot wrong");
  a_no_diff_quiet: assert property ((in_level == in_ref && $stable(in_ref))[*2] |->
    !irq_pending) else $error("irq without change");
  a_irq_pin_low: assert property (!irq_pin_is_output |=>
    irq_or_extra_output_pin_oe == irq_pending) else $error("irq pin wrong");
  a_static_phase0: assert property (s_static(1'b0) |->
    port_pin_oe == (~out_cfg.phase0[15:0] & ~port_is_input)) else $error("static out wrong");
  a_blink_select: assert property (s_static(1'b1) |-> port_pin_oe ==
    (~(out_cfg.blink_flip ? out_cfg.phase1[15:0] : out_cfg.phase0[15:0]) & ~port_is_input))
    else $error("blink out wrong");
  a_osc_request: assert property (##1 osc_enable == $past(|pwm_cfg.out_en))
    else $error("oscillator request wrong");
  a_standby_idle: assert property ((!serial_busy && pwm_cfg.out_en == '0) |=> standby)
    else $error("no standby");
endmodule
bind gbpe_top gbpe_top_assertions i_chk (.clk_sys, .sys_rst, .port_pin_oe,
  .irq_or_extra_output_pin_oe, .port_is_input, .irq_pin_is_output, .out_cfg, .pwm_cfg,
  .in_read_lo, .serial_busy, .in_level, .in_ref, .irq_pending, .osc_enable, .standby);

// file: test/gbpe_pin_model.sv
// pin and oscillator model: pulled-up open-drain pins, gated pwm oscillator
// assumes: ext_low comes from the bench, 800 ns oscillator period
`timescale 1ns/1ps
module gbpe_pin_model (
  input  wire logic [15:0] port_pin_oe,
  input  wire logic [15:0] ext_low,
  input  wire logic        osc_enable,
  output logic      [15:0] port_pin_i,
  output logic             pwm_osc_clk = 1'b0
);
  assign port_pin_i = ~(port_pin_oe | ext_low);
  always #400 pwm_osc_clk = osc_enable & ~pwm_osc_clk;
endmodule

// file: test/gbpe_top_tb_top.sv
// bench: drives config, pins and read pulses, checks levels, irq and pwm
// assumes: gbpe_pkg compiled first, pins via gbpe_pin_model
`timescale 1ns/1ps
module gbpe_top_tb_top
  import gbpe_pkg::*;
;
  logic          clk_sys = 0;
  logic          sys_rst = 1;
  logic          serial_busy = 1;
  logic          in_read_lo = 0;
  logic          in_read_hi = 0;
  logic          irq_pin_is_output = 0;
  logic          irq_or_extra_output_pin_oe, pwm_osc_clk, irq_pending, osc_enable, standby;
  logic          irq_or_extra_output_pin_o;
  logic [15:0]   port_is_input = '1, ext_low = '0, port_pin_i, port_pin_oe, in_level, in_ref;
  logic [15:0]   port_pin_o;
  gbpe_out_cfg_t out_cfg = '{phase0: '1, phase1: '1, default: '0};
  gbpe_pwm_cfg_t pwm_cfg = '0;
  int            n_fail = 0, cmp_count = 0;
  always #50 clk_sys = ~clk_sys;
  gbpe_top i_dut (.clk_sys, .sys_rst, .port_pin_i, .port_pin_o, .port_pin_oe,
    .irq_or_extra_output_pin_o, .irq_or_extra_output_pin_oe, .pwm_osc_clk, .port_is_input,
    .irq_pin_is_output, .out_cfg, .pwm_cfg, .in_read_lo, .in_read_hi, .serial_busy,
    .in_level, .in_ref, .irq_pending, .osc_enable, .standby);
  gbpe_pin_model i_pins (.port_pin_oe, .ext_low, .osc_enable, .port_pin_i, .pwm_osc_clk);
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic clks(int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic rd(bit h);
    if (h) in_read_hi <= 1;
    else in_read_lo <= 1;
    clks(1);
    in_read_hi <= 0;
    in_read_lo <= 0;
    clks(1);
  endtask
  task automatic pwm(logic g, logic [7:0] lv, logic [3:0] m, logic [3:0] iv, int exp);
    int n = 0;
    pwm_cfg.global_en <= g;
    pwm_cfg.global_lvl <= lv;
    pwm_cfg.master <= m;
    pwm_cfg.indiv[3] <= iv;
    clks(2000);
    repeat (1920) begin
      clks(1);
      n += port_pin_oe[3];
    end
    chk("pwm on time", n, exp);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    clks(4);
    sys_rst <= 0;
    clks(6);
    chk("oe", port_pin_oe, 0);
    chk("level", in_level, 16'hffff);
    chk("irq", irq_pending, 1);
    rd(0);
    chk("irq lo read", irq_pending, 1);
    rd(1);
    chk("ref", in_ref, 16'hffff);
    chk("irq hi read", irq_pending, 0);
    ext_low <= 16'h0008;
    clks(5);
    chk("irq change", irq_pending, 1);
    chk("irq pin", irq_or_extra_output_pin_oe, 1);
    ext_low <= 16'h0000;
    clks(5);
    chk("irq return", irq_pending, 0);
    ext_low <= 16'h0008;
    clks(5);
    rd(0);
    chk("ref lo", in_ref, 16'hfff7);
    chk("irq read", irq_pending, 0);
    $display("test inputs done");
    port_is_input <= 16'hfff7;
    out_cfg.phase0[3] <= 0;
    clks(6);
    out_cfg.phase0[4] <= 0;
    ext_low <= 16'h0000;
    clks(6);
    chk("oe out", port_pin_oe, 16'h0008);
    chk("level out", in_level[3], 0);
    out_cfg.blink_en <= 1;
    out_cfg.blink_flip <= 1;
    clks(4);
    chk("oe phase1", port_pin_oe, 0);
    out_cfg.blink_flip <= 0;
    clks(4);
    chk("oe phase0", port_pin_oe, 16'h0008);
    out_cfg.blink_en <= 0;
    out_cfg.blink_flip <= 1;
    irq_pin_is_output <= 1;
    out_cfg.phase0[16] <= 0;
    clks(4);
    chk("oe no blink", port_pin_oe, 16'h0008);
    chk("pin 16", irq_or_extra_output_pin_oe, 1);
    $display("test outputs done");
    pwm_cfg.out_en[3] <= 1;
    serial_busy <= 0;
    pwm(0, 0, 15, 8, 960);
    pwm(0, 0, 1, 15, 120);
    pwm(0, 0, 15, 15, 1800);
    pwm(1, 60, 0, 0, 480);
    chk("osc on", osc_enable, 1);
    chk("awake", standby, 0);
    $display("test pwm done");
    pwm_cfg.out_en <= '0;
    clks(4);
    chk("osc off", osc_enable, 0);
    chk("standby", standby, 1);
    chk("static", port_pin_oe, 16'h0008);
    chk("pin data", {irq_or_extra_output_pin_o, port_pin_o}, 0);
    $display("test standby done");
    give_verdict();
  end
endmodule
